// ---- trs_far.sv ----
`timescale 1ns/1ps
module trs_far (
  input wire logic front_out,
  input wire logic front_oe,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic ext_front,
  input wire logic [7:0] ext_bus,
  output logic front_in,
  output logic [7:0] bus_in
);
  // Device drive wins, else the far instrument
  assign front_in = front_oe ? front_out : ext_front;
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & ext_bus);
endmodule

// ---- trs_pkg.sv ----
package trs_pkg;

  // Selection codes, 7 bits wide
  localparam int sel_w = 7;
  localparam logic [6:0] select_nothing = 7'h00;
  localparam logic [6:0] select_front_connector = 7'h02;
  localparam logic [6:0] select_software_level = 7'h03;
  localparam logic [6:0] select_bus_line_zero = 7'h6f;
  localparam logic [6:0] select_bus_line_seven = 7'h76;

  // Software level encodings
  localparam logic level_low = 1'b0;
  localparam logic level_high = 1'b1;

  // Synchroniser depth
  localparam int sync_stages = 2;

  typedef enum logic [1:0] {
    trs_ok = 2'h0,
    trs_not_opened = 2'h1,
    trs_bad_path = 2'h3
  } trs_status_t;

  // Command strobes from the control side
  typedef struct packed {
    logic open;
    logic shutdown;
    logic set_level;
    logic level;
    logic route;
    logic clear;
    logic [6:0] src;
    logic [6:0] dst;
    logic [6:0] via;
  } trs_cmd_t;

  // Answers and readback
  typedef struct packed {
    logic done;
    trs_status_t status;
    logic opened;
    logic level;
    logic [6:0] src;
    logic [6:0] dst;
    logic [6:0] via;
  } trs_resp_t;

endpackage

// ---- trs_route_switch.sv ----
`timescale 1ns/1ps
module trs_route_switch #(
  parameter int NUM_BUS = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire trs_pkg::trs_cmd_t cmd,
  output trs_pkg::trs_resp_t resp,
  input wire logic front_in,
  output logic front_out,
  output logic front_oe,
  input wire logic [NUM_BUS-1:0] bus_in,
  output logic [NUM_BUS-1:0] bus_out,
  output logic [NUM_BUS-1:0] bus_oe
);

  typedef struct packed {
    trs_pkg::trs_resp_t resp;
    logic front_out;
    logic front_oe;
    logic [NUM_BUS-1:0] bus_out;
    logic [NUM_BUS-1:0] bus_oe;
  } trs_state_t;

  trs_state_t state_reg;
  trs_state_t state_next;
  logic [NUM_BUS:0] pins_sync;
  logic front_s;
  logic [NUM_BUS-1:0] bus_s;

  // Refuse builds that the code space or the logic cannot serve
  initial begin
    if (NUM_BUS < 1 || NUM_BUS > 8) begin
      $error("NUM_BUS must be 1 to 8");
    end
    if ($bits(trs_pkg::select_nothing) != trs_pkg::sel_w) begin
      $error("selection codes must match the selection width");
    end
    if (int'(trs_pkg::select_bus_line_zero) + NUM_BUS > (1 << trs_pkg::sel_w)) begin
      $error("bus line codes overflow the selection width");
    end
    if (trs_pkg::sync_stages != 2) begin
      $error("pin synchroniser has exactly two stages");
    end
    if (trs_pkg::select_software_level == trs_pkg::select_front_connector) begin
      $error("source codes must differ");
    end
    if (trs_pkg::select_nothing == trs_pkg::select_front_connector) begin
      $error("none code must differ from the connector code");
    end
    if (trs_pkg::level_low == trs_pkg::level_high) begin
      $error("level encodings must differ");
    end
    if (trs_pkg::select_bus_line_seven < trs_pkg::select_bus_line_zero) begin
      $error("bus line codes must ascend");
    end
  end

  // Pins pass two flip-flops before use
  trs_sync #(
    .W(NUM_BUS + 1)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .d({front_in, bus_in}),
    .q(pins_sync)
  );

  assign front_s = pins_sync[NUM_BUS];
  assign bus_s = pins_sync[NUM_BUS-1:0];

  // True for a bus line code within this build
  function automatic logic is_bus(input logic [6:0] code);
    logic [6:0] last;
    last = 7'(trs_pkg::select_bus_line_zero + 7'(NUM_BUS - 1));
    is_bus = (code >= trs_pkg::select_bus_line_zero) && (code <= last);
  endfunction

  // Bus line index of a bus line code
  function automatic logic [2:0] bus_idx(input logic [6:0] code);
    logic [6:0] diff;
    diff = code - trs_pkg::select_bus_line_zero;
    bus_idx = diff[2:0];
  endfunction

  // Level of the stored source, low when no source is selected
  function automatic logic level_of(input trs_pkg::trs_resp_t r, input logic fr,
                                    input logic [NUM_BUS-1:0] bl);
    logic [2:0] si;
    si = bus_idx(r.src);
    level_of = trs_pkg::level_low;
    if (r.src == trs_pkg::select_software_level) begin
      level_of = r.level;
    end else if (r.src == trs_pkg::select_front_connector) begin
      level_of = fr;
    end else if (is_bus(r.src)) begin
      level_of = bl[si];
    end
  endfunction

  // Valid source, destination and via combination
  function automatic logic path_ok(input logic [6:0] s, input logic [6:0] d,
                                   input logic [6:0] v);
    logic s_ok;
    logic d_ok;
    logic v_ok;
    s_ok = is_bus(s) || (s == trs_pkg::select_front_connector) ||
           (s == trs_pkg::select_software_level);
    d_ok = is_bus(d) || (d == trs_pkg::select_front_connector);
    if (s == trs_pkg::select_software_level && d == trs_pkg::select_front_connector) begin
      v_ok = is_bus(v);
    end else begin
      v_ok = (v == trs_pkg::select_nothing);
    end
    path_ok = s_ok && d_ok && v_ok && (s != d);
  endfunction

  always_comb begin
    logic src_level;
    logic [2:0] di;
    logic [2:0] vi;
    src_level = 1'b0;
    di = '0;
    vi = '0;
    state_next = state_reg;
    if (clk_en) begin
      state_next.resp.done = 1'b0;
      // Command decode, one command per cycle
      if (cmd.open) begin
        state_next.resp.opened = 1'b1;
        state_next.resp.done = 1'b1;
        state_next.resp.status = trs_pkg::trs_ok;
      end else if (cmd.shutdown || cmd.clear || cmd.route || cmd.set_level) begin
        state_next.resp.done = 1'b1;
        if (!state_reg.resp.opened) begin
          state_next.resp.status = trs_pkg::trs_not_opened;
        end else if (cmd.shutdown) begin
          state_next.resp.opened = 1'b0;
          state_next.resp.status = trs_pkg::trs_ok;
        end else if (cmd.clear) begin
          state_next.resp.src = trs_pkg::select_nothing;
          state_next.resp.dst = trs_pkg::select_nothing;
          state_next.resp.via = trs_pkg::select_nothing;
          state_next.resp.status = trs_pkg::trs_ok;
        end else if (cmd.route) begin
          if (path_ok(cmd.src, cmd.dst, cmd.via)) begin
            state_next.resp.src = cmd.src;
            state_next.resp.dst = cmd.dst;
            state_next.resp.via = cmd.via;
            state_next.resp.status = trs_pkg::trs_ok;
          end else begin
            state_next.resp.status = trs_pkg::trs_bad_path;
          end
        end else begin
          state_next.resp.level = cmd.level;
          state_next.resp.status = trs_pkg::trs_ok;
        end
      end

      // Pin drive from the stored route
      di = bus_idx(state_reg.resp.dst);
      vi = bus_idx(state_reg.resp.via);
      src_level = level_of(state_reg.resp, front_s, bus_s);
      state_next.front_oe = 1'b0;
      state_next.front_out = 1'b0;
      state_next.bus_oe = '0;
      state_next.bus_out = '0;
      if (state_reg.resp.dst == trs_pkg::select_front_connector) begin
        state_next.front_oe = 1'b1;
        state_next.front_out = src_level;
        if (is_bus(state_reg.resp.via)) begin
          state_next.bus_oe[vi] = 1'b1;
          state_next.bus_out[vi] = src_level;
        end
      end else if (is_bus(state_reg.resp.dst)) begin
        state_next.bus_oe[di] = 1'b1;
        state_next.bus_out[di] = src_level;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign resp = state_reg.resp;
  assign front_out = state_reg.front_out;
  assign front_oe = state_reg.front_oe;
  assign bus_out = state_reg.bus_out;
  assign bus_oe = state_reg.bus_oe;

endmodule

// ---- trs_route_switch_asserts.sv ----
`timescale 1ns/1ps
module trs_route_switch_asserts #(
  parameter int NUM_BUS = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire trs_pkg::trs_cmd_t cmd,
  input wire trs_pkg::trs_resp_t resp,
  input wire logic front_in,
  input wire logic front_out,
  input wire logic front_oe,
  input wire logic [NUM_BUS-1:0] bus_in,
  input wire logic [NUM_BUS-1:0] bus_out,
  input wire logic [NUM_BUS-1:0] bus_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic hi = clk_en && !cmd.open && !cmd.shutdown;
  wire logic clr = hi && cmd.clear;
  wire logic rte = hi && !cmd.clear && cmd.route;
  wire logic lvl = hi && !cmd.clear && !cmd.route && cmd.set_level;
  property p_answer;
    (clk_en && (cmd.open || cmd.shutdown)) || clr || rte || lvl |=> resp.done;
  endproperty
  a_answer: assert property (p_answer) else $error("no done");
  property p_refuse;
    lvl && !resp.opened |=> resp.status == trs_pkg::trs_not_opened && $stable(resp.level);
  endproperty
  a_refuse: assert property (p_refuse) else $error("not refused");
  property p_level;
    lvl && resp.opened |=> resp.level == $past(cmd.level);
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_boot;
    $past(reset) |-> !resp.level && resp.src == 7'h00 && bus_oe == '0 && !front_oe;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state");
  property p_bad;
    rte && resp.opened && cmd.dst == 7'h03 |=> resp.status == trs_pkg::trs_bad_path
      && $stable(resp.dst);
  endproperty
  a_bad: assert property (p_bad) else $error("bad dst taken");
  property p_via;
    resp.via != 7'h00 |-> resp.src == 7'h03 && resp.dst == 7'h02;
  endproperty
  a_via: assert property (p_via) else $error("via misuse");
  property p_clear;
    clr && resp.opened |=> resp.src == 7'h00 ##1 bus_oe == '0 && !front_oe;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_pin;
    (clk_en && resp.src == 7'h72 && resp.dst == 7'h02) [*4] |-> front_oe
      && front_out == $past(bus_in[3], 3);
  endproperty
  a_pin: assert property (p_pin) else $error("pin path");
  property p_sw;
    (clk_en && resp.src == 7'h03 && resp.dst == 7'h02 && resp.via == 7'h74) [*3] |-> front_oe
      && bus_oe[5] && bus_out[5] == $past(resp.level) && front_out == $past(resp.level);
  endproperty
  a_sw: assert property (p_sw) else $error("soft drive");
  c_lvl: cover property (lvl && resp.opened);
  c_clr: cover property (clr && resp.opened);
  c_bad: cover property (rte && resp.opened && cmd.dst == 7'h03);
endmodule

// ---- trs_route_switch_tb.sv ----
`timescale 1ns/1ps
module trs_route_switch_tb;
  logic mclk, reset, clk_en, ext_front, front_in, front_out, front_oe;
  logic [7:0] ext_bus, bus_in, bus_out, bus_oe;
  trs_pkg::trs_cmd_t cmd;
  trs_pkg::trs_resp_t resp;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  trs_route_switch #(.NUM_BUS(8)) u_dut (.mclk(mclk), .reset(reset), .clk_en(clk_en),
    .cmd(cmd), .resp(resp), .front_in(front_in), .front_out(front_out),
    .front_oe(front_oe), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));
  trs_far u_far (.front_out(front_out), .front_oe(front_oe), .bus_out(bus_out),
    .bus_oe(bus_oe), .ext_front(ext_front), .ext_bus(ext_bus), .front_in(front_in),
    .bus_in(bus_in));
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobes: open shutdown set_level level route clear
  task automatic go(logic [5:0] st, logic [6:0] s, logic [6:0] d, logic [6:0] v,
                    logic [1:0] es);
    @(negedge mclk);
    cmd = {st, s, d, v};
    @(negedge mclk);
    cmd = '0;
    chk("done", resp.done, 1'b1);
    chk("status", resp.status, es);
  endtask
  task automatic t_boot();
    chk("level", resp.level, 1'b0);
    chk("route", {resp.src, resp.dst, resp.via}, 21'h0);
    go(6'h0c, 7'h00, 7'h00, 7'h00, 2'h1);
    chk("level", resp.level, 1'b0);
    $display("boot done");
  endtask
  task automatic t_level();
    go(6'h20, 7'h00, 7'h00, 7'h00, 2'h0);
    go(6'h0c, 7'h00, 7'h00, 7'h00, 2'h0);
    chk("level", resp.level, 1'b1);
    go(6'h08, 7'h00, 7'h00, 7'h00, 2'h0);
    chk("level", resp.level, 1'b0);
    $display("level done");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      go(6'h02, 7'h6f + 7'(i), 7'h02, 7'h00, 2'h0);
      chk("src", resp.src, 7'h6f + 7'(i));
      go(6'h02, 7'h02, 7'h6f + 7'(i), 7'h00, 2'h0);
      chk("dst", resp.dst, 7'h6f + 7'(i));
      @(negedge mclk);
      chk("oe", {front_oe, bus_oe}, {1'b0, 8'h01 << i});
    end
    go(6'h02, 7'h02, 7'h03, 7'h00, 2'h3);
    go(6'h02, 7'h02, 7'h6f, 7'h6f, 2'h3);
    chk("kept", resp.dst, 7'h76);
    $display("codes done");
  endtask
  task automatic t_pins();
    go(6'h02, 7'h03, 7'h02, 7'h74, 2'h0);
    chk("via", resp.via, 7'h74);
    go(6'h0c, 7'h00, 7'h00, 7'h00, 2'h0);
    @(negedge mclk);
    chk("soft", {front_oe, front_out, bus_oe, bus_out & bus_oe}, 18'h32020);
    go(6'h02, 7'h72, 7'h02, 7'h00, 2'h0);
    ext_bus = 8'h08;
    repeat (4) @(negedge mclk);
    chk("pin", {front_oe, front_out}, 2'h3);
    ext_bus = 8'h00;
    repeat (4) @(negedge mclk);
    chk("pin", front_out, 1'b0);
    $display("pins done");
  endtask
  task automatic t_clear();
    go(6'h01, 7'h00, 7'h00, 7'h00, 2'h0);
    chk("route", {resp.src, resp.dst, resp.via}, 21'h0);
    @(negedge mclk);
    chk("oe", {front_oe, bus_oe}, 9'h0);
    go(6'h10, 7'h00, 7'h00, 7'h00, 2'h0);
    chk("opened", resp.opened, 1'b0);
    go(6'h01, 7'h00, 7'h00, 7'h00, 2'h1);
    $display("clear done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    cmd = '0;
    ext_front = 1'b0;
    ext_bus = 8'h00;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_boot();
    t_level();
    t_codes();
    t_pins();
    t_clear();
    end_sim();
  end
endmodule
bind trs_route_switch trs_route_switch_asserts #(.NUM_BUS(NUM_BUS)) u_chk (.mclk(mclk),
  .reset(reset), .clk_en(clk_en), .cmd(cmd), .resp(resp), .front_in(front_in),
  .front_out(front_out), .front_oe(front_oe), .bus_in(bus_in), .bus_out(bus_out),
  .bus_oe(bus_oe));

// ---- trs_sync.sv ----
`timescale 1ns/1ps
module trs_sync #(
  parameter int W = 9
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } trs_sync_state_t;

  trs_sync_state_t state_reg;
  trs_sync_state_t state_next;

  initial begin
    if (W < 1) $error("trs_sync width must be at least one");
  end

  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      state_next.s1 = d;
      state_next.s2 = state_reg.s1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.s2;

endmodule
